// ==== hw/bdm_pkg.sv ====
// shared types and constants of the brake demand manager
package bdm_pkg;

   // default number of supervision functions that may request braking
   localparam int NUM_FUNCS = 8;

   // driver display button positions in the enable vector
   localparam int NUM_BUTTONS = 8;
   localparam int BTN_BRIGHTNESS = 0;
   localparam int BTN_TEXT_ERROR_ACK = 1;
   localparam int BTN_SPEED_RESTRICTION_ACK = 2;
   localparam int BTN_RUNNING_RELEASE = 3;

   // buttons that stay usable during an emergency brake in every mode
   localparam logic [NUM_BUTTONS-1:0] KEEP_MASK = 8'h07;
   localparam logic [NUM_BUTTONS-1:0] ALL_BUTTONS = 8'hFF;

   // reset value of the registered demand held by a release gate
   localparam logic HELD_RESET = 1'b0;

   typedef enum logic [1:0] {
      BDM_MODE_OTHER = 2'h0,
      BDM_MODE_AUTO_PROTECTION = 2'h1,
      BDM_MODE_COMBINED_PROTECTION = 2'h3
   } bdm_mode_e;

   typedef struct packed {
      logic serviceBrakeConfigured;
      logic tractionCutOffConfigured;
   } bdm_cfg_s;

   typedef struct packed {
      logic tractionCutOff;
      logic serviceBrake;
      logic emergencyBrake;
      logic serviceBrakeTone;
      logic emergencyBrakeTone;
      logic serviceBrakeIcon;
      logic emergencyBrakeIcon;
      logic serviceBrakeMonitor;
      logic [NUM_BUTTONS-1:0] buttonEnable;
   } bdm_out_s;

   localparam bdm_out_s OUT_RESET = '{
      tractionCutOff: 1'b0,
      serviceBrake: 1'b0,
      emergencyBrake: 1'b0,
      serviceBrakeTone: 1'b0,
      emergencyBrakeTone: 1'b0,
      serviceBrakeIcon: 1'b0,
      emergencyBrakeIcon: 1'b0,
      serviceBrakeMonitor: 1'b0,
      buttonEnable: ALL_BUTTONS
   };

endpackage : bdm_pkg

// ==== hw/bdm_release_gate.sv ====
// holds one brake demand until all requests are gone and traction is idle
`timescale 1ns/1ps
module bdm_release_gate #(
   parameter int NUM_FUNCS = bdm_pkg::NUM_FUNCS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [NUM_FUNCS-1:0] requests,
   input wire logic tractionDemand,
   output logic held
);

   typedef struct packed {
      logic held;
   } bdm_gate_s;

   bdm_gate_s state_q;
   bdm_gate_s state_d;

   always_comb
   begin
      state_d = state_q;
      if (|requests)
      begin
         // a new request always wins over a pending release
         state_d.held = 1'b1;
      end
      else if (!tractionDemand)
      begin
         // release waits for coast or brake position of the controller
         state_d.held = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q.held <= bdm_pkg::HELD_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign held = state_q.held;

endmodule : bdm_release_gate

// ==== hw/bdm_brake_demand_manager.sv ====
// brake demand manager: merges brake requests and drives brake, sound, icon and button outputs
`timescale 1ns/1ps
module bdm_brake_demand_manager #(
   parameter int NUM_FUNCS = bdm_pkg::NUM_FUNCS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [NUM_FUNCS-1:0] serviceRequest,
   input wire logic [NUM_FUNCS-1:0] emergencyRequest,
   input wire bdm_pkg::bdm_cfg_s cfg,
   input wire bdm_pkg::bdm_mode_e protectionMode,
   input wire logic tractionDemand,
   output bdm_pkg::bdm_out_s brakeOut
);

   typedef struct packed {
      logic [NUM_FUNCS-1:0] sbFlags;
      logic [NUM_FUNCS-1:0] ebFlags;
      bdm_pkg::bdm_out_s outs;
   } bdm_state_s;

   bdm_state_s state_q;
   bdm_state_s state_d;

   logic [NUM_FUNCS-1:0] sbGateReq;
   logic [NUM_FUNCS-1:0] ebGateReq;
   logic sbHeld;
   logic ebHeld;
   logic sbActive;
   logic releaseAllowed;
   logic [bdm_pkg::NUM_BUTTONS-1:0] emergencyMask;

   // service requests go to the service gate only when that brake exists
   assign sbGateReq = state_q.sbFlags & {NUM_FUNCS{cfg.serviceBrakeConfigured}};
   // otherwise they join the emergency requests as a stand-in demand
   assign ebGateReq = state_q.ebFlags
      | (state_q.sbFlags & {NUM_FUNCS{~cfg.serviceBrakeConfigured}});

   bdm_release_gate #(
      .NUM_FUNCS(NUM_FUNCS)
   ) serviceGate (
      .clk(clk),
      .reset_n(reset_n),
      .requests(sbGateReq),
      .tractionDemand(tractionDemand),
      .held(sbHeld)
   );

   bdm_release_gate #(
      .NUM_FUNCS(NUM_FUNCS)
   ) emergencyGate (
      .clk(clk),
      .reset_n(reset_n),
      .requests(ebGateReq),
      .tractionDemand(tractionDemand),
      .held(ebHeld)
   );

   assign sbActive = sbHeld & cfg.serviceBrakeConfigured;
   assign releaseAllowed = (protectionMode == bdm_pkg::BDM_MODE_AUTO_PROTECTION)
      || (protectionMode == bdm_pkg::BDM_MODE_COMBINED_PROTECTION);

   // per button mask used while the emergency brake is demanded
   genvar b;
   generate
      for (b = 0; b < bdm_pkg::NUM_BUTTONS; b++)
      begin : gen_button
         if (b == bdm_pkg::BTN_RUNNING_RELEASE)
         begin : gen_release
            assign emergencyMask[b] = releaseAllowed;
         end
         else
         begin : gen_other
            assign emergencyMask[b] = bdm_pkg::KEEP_MASK[b];
         end
      end
   endgenerate

   always_comb
   begin
      state_d = state_q;
      // flags mirror the live requests so a revoke is seen on the next edge
      state_d.sbFlags = serviceRequest;
      state_d.ebFlags = emergencyRequest;
      state_d.outs.tractionCutOff = cfg.tractionCutOffConfigured
         & (sbActive | ebHeld);
      state_d.outs.serviceBrake = cfg.serviceBrakeConfigured
         & (sbHeld | ebHeld);
      state_d.outs.emergencyBrake = ebHeld;
      state_d.outs.serviceBrakeTone = sbActive;
      state_d.outs.serviceBrakeIcon = sbActive;
      state_d.outs.serviceBrakeMonitor = sbActive;
      state_d.outs.emergencyBrakeTone = ebHeld;
      state_d.outs.emergencyBrakeIcon = ebHeld;
      state_d.outs.buttonEnable = ebHeld ? emergencyMask : bdm_pkg::ALL_BUTTONS;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q.sbFlags <= '0;
         state_q.ebFlags <= '0;
         state_q.outs <= bdm_pkg::OUT_RESET;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign brakeOut = state_q.outs;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_sb_req;
      (|state_q.sbFlags) && cfg.serviceBrakeConfigured;
   endsequence

   sequence s_sb_outs_on;
      brakeOut.serviceBrake && brakeOut.serviceBrakeTone
         && brakeOut.serviceBrakeIcon && brakeOut.serviceBrakeMonitor;
   endsequence

   property p_sb_actions;
      s_sb_req |-> ##2 s_sb_outs_on;
   endproperty
   a_sb_actions: assert property (p_sb_actions)
      else $error("service brake outputs missing");

   property p_sb_substitute;
      ((|state_q.sbFlags) && !cfg.serviceBrakeConfigured) |-> ##2 brakeOut.emergencyBrake;
   endproperty
   a_sb_substitute: assert property (p_sb_substitute)
      else $error("no emergency stand-in for service brake");

   property p_eb_actions;
      ebHeld |=> (brakeOut.emergencyBrake && brakeOut.emergencyBrakeTone
         && brakeOut.emergencyBrakeIcon
         && brakeOut.serviceBrake == $past(cfg.serviceBrakeConfigured)
         && brakeOut.tractionCutOff == $past(cfg.tractionCutOffConfigured));
   endproperty
   a_eb_actions: assert property (p_eb_actions)
      else $error("emergency brake outputs wrong");

   property p_eb_buttons;
      ebHeld |=> (brakeOut.buttonEnable[bdm_pkg::BTN_RUNNING_RELEASE] == $past(releaseAllowed)
         && (brakeOut.buttonEnable & ~bdm_pkg::KEEP_MASK
            & ~(8'h01 << bdm_pkg::BTN_RUNNING_RELEASE)) == 8'h00
         && (brakeOut.buttonEnable & bdm_pkg::KEEP_MASK) == bdm_pkg::KEEP_MASK);
   endproperty
   a_eb_buttons: assert property (p_eb_buttons)
      else $error("button inhibit wrong during emergency brake");

   property p_sb_release_blocked;
      (sbHeld && tractionDemand) |=> sbHeld;
   endproperty
   a_sb_release_blocked: assert property (p_sb_release_blocked)
      else $error("service brake released under traction demand");

   property p_sub_withdraw;
      (!(|state_q.sbFlags) && !(|state_q.ebFlags) && !tractionDemand) |-> ##2
         !brakeOut.emergencyBrake;
   endproperty
   a_sub_withdraw: assert property (p_sub_withdraw)
      else $error("emergency demand not withdrawn");

   property p_eb_release;
      $fell(brakeOut.emergencyBrake) |-> !$past(tractionDemand, 2)
         && brakeOut.buttonEnable == bdm_pkg::ALL_BUTTONS;
   endproperty
   a_eb_release: assert property (p_eb_release)
      else $error("emergency release without traction idle");

   property p_sb_hold;
      s_sb_req |=> sbHeld;
   endproperty
   a_sb_hold: assert property (p_sb_hold)
      else $error("service demand dropped with a request pending");

   property p_eb_hold;
      (|state_q.ebFlags) |=> ebHeld;
   endproperty
   a_eb_hold: assert property (p_eb_hold)
      else $error("emergency demand dropped with a request pending");

   property p_flags_track;
      1'b1 |=> state_q.sbFlags == $past(serviceRequest)
         && state_q.ebFlags == $past(emergencyRequest);
   endproperty
   a_flags_track: assert property (p_flags_track)
      else $error("request flags do not follow requests");

   // a request arriving with the traction drop legally keeps the demand
   property p_late_release;
      (ebHeld && !(|ebGateReq) && tractionDemand)
         ##1 (!tractionDemand && !(|ebGateReq)) |=> !ebHeld;
   endproperty
   a_late_release: assert property (p_late_release)
      else $error("pending release not applied");

   property p_sb_late_release;
      (sbHeld && !(|sbGateReq) && tractionDemand)
         ##1 (!tractionDemand && !(|sbGateReq)) |=> !sbHeld;
   endproperty
   a_sb_late_release: assert property (p_sb_late_release)
      else $error("pending service release not applied");

   property p_tco_config;
      brakeOut.tractionCutOff |-> $past(cfg.tractionCutOffConfigured);
   endproperty
   a_tco_config: assert property (p_tco_config)
      else $error("traction cut off without configuration");

endmodule : bdm_brake_demand_manager

// ==== test/bdm_traction_ctrl.sv ====
// traction controller model answering for the driver handle
`timescale 1ns/1ps
module bdm_traction_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wantTraction,
   input wire logic slow,
   output logic tractionDemand
);
   logic [2:0] lag_q;
   // slow driver: handle reaches coast late, so release must wait for it
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         tractionDemand <= 1'b0;
         lag_q <= 3'h0;
      end
      else if (wantTraction)
      begin
         tractionDemand <= 1'b1;
         lag_q <= slow ? 3'h5 : 3'h0;
      end
      else if (lag_q != 3'h0)
         lag_q <= lag_q - 3'h1;
      else
         tractionDemand <= 1'b0;
endmodule : bdm_traction_ctrl

// ==== test/testbench.sv ====
// self-checking bench of the brake demand manager
`timescale 1ns/1ps
module testbench;
   logic clk;
   logic reset_n;
   logic [7:0] sReq;
   logic [7:0] eReq;
   logic want;
   logic slow;
   logic tractionDemand;
   logic sbHeld;
   logic ebHeld;
   bdm_pkg::bdm_cfg_s cfg;
   bdm_pkg::bdm_mode_e mode;
   bdm_pkg::bdm_out_s brakeOut;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;

   bdm_brake_demand_manager #(.NUM_FUNCS(8)) dut (
      .clk(clk),
      .reset_n(reset_n),
      .serviceRequest(sReq),
      .emergencyRequest(eReq),
      .cfg(cfg),
      .protectionMode(mode),
      .tractionDemand(tractionDemand),
      .brakeOut(brakeOut)
   );

   bdm_traction_ctrl partner (
      .clk(clk),
      .reset_n(reset_n),
      .wantTraction(want),
      .slow(slow),
      .tractionDemand(tractionDemand)
   );

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   // hang guard, well above the ~2350 cycles the sequence needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         n_mismatch++;
         final_report();
      end
   end

   function automatic bdm_pkg::bdm_out_s expOut(input logic sb, input logic eb);
      bdm_pkg::bdm_out_s o;
      o = bdm_pkg::OUT_RESET;
      if (sb)
      begin
         o.tractionCutOff = cfg.tractionCutOffConfigured;
         {o.serviceBrake, o.serviceBrakeTone, o.serviceBrakeIcon, o.serviceBrakeMonitor} = 4'hF;
      end
      if (eb)
      begin
         o.tractionCutOff = o.tractionCutOff | cfg.tractionCutOffConfigured;
         o.serviceBrake = o.serviceBrake | cfg.serviceBrakeConfigured;
         {o.emergencyBrake, o.emergencyBrakeTone, o.emergencyBrakeIcon} = 3'h7;
         o.buttonEnable = bdm_pkg::KEEP_MASK;
         o.buttonEnable[bdm_pkg::BTN_RUNNING_RELEASE] = (mode != bdm_pkg::BDM_MODE_OTHER);
      end
      return o;
   endfunction : expOut

   task automatic check(input bdm_pkg::bdm_out_s exp);
      cmp_count++;
      if (brakeOut !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, brakeOut, exp);
      end
   endtask : check

   // inputs held 12 edges: covers the 3-edge path plus the slow handle
   task automatic step(input logic [7:0] s, input logic [7:0] e, input logic tr);
      sReq = s;
      eReq = e;
      want = tr;
      slow = 1'($urandom);
      repeat (12) @(posedge clk);
      #10;
      sbHeld = (|s & cfg.serviceBrakeConfigured) | (sbHeld & tr);
      ebHeld = |e | (|s & !cfg.serviceBrakeConfigured) | (ebHeld & tr);
      check(expOut(sbHeld, ebHeld));
   endtask : step

   initial
   begin
      void'($urandom(71));
      reset_n = 1'b0;
      sReq = 8'h00;
      eReq = 8'h00;
      want = 1'b0;
      slow = 1'b0;
      cfg = 2'h3;
      mode = bdm_pkg::BDM_MODE_OTHER;
      sbHeld = 1'b0;
      ebHeld = 1'b0;
      repeat (3) @(posedge clk);
      #10;
      check(bdm_pkg::OUT_RESET);
      reset_n = 1'b1;
      step(8'h01, 8'h00, 1'b1);
      step(8'h00, 8'h00, 1'b1);
      step(8'h00, 8'h00, 1'b0);
      step(8'h03, 8'h00, 1'b0);
      step(8'h02, 8'h00, 1'b0);
      step(8'h00, 8'h00, 1'b0);
      for (int m = 0; m < 3; m++)
      begin
         mode = bdm_pkg::bdm_mode_e'(2'(m == 2 ? 3 : m));
         step(8'h00, 8'h81, 1'b1);
         step(8'h00, 8'h80, 1'b0);
         step(8'h00, 8'h00, 1'b1);
         step(8'h00, 8'h00, 1'b0);
      end
      cfg.serviceBrakeConfigured = 1'b0;
      step(8'h04, 8'h00, 1'b0);
      step(8'h00, 8'h00, 1'b0);
      // configuration only changes once every demand is gone
      for (int r = 0; r < 25; r++)
      begin
         cfg = 2'($urandom);
         mode = bdm_pkg::bdm_mode_e'(2'($urandom % 2) * 2'($urandom % 2 + 2) / 2);
         repeat (6) step(8'($urandom & $urandom & $urandom),
            8'($urandom & $urandom), 1'($urandom));
         step(8'h00, 8'h00, 1'b0);
      end
      final_report();
   end
endmodule : testbench
